// file: two_wire_master_slave_bus_unit.sv
// Two-wire bus unit: independent master and slave on shared open-drain pins
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_params.svh"

// Functional notes
// - Bus idle only while data and clock lines are both high.
// - Each byte is eight data bits plus one acknowledge bit.
// - Data bits are shifted most significant bit first.
// - A receiver may hold clock low; the transmitter waits for release.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Bus is busy from a seen start until the next seen stop.
// - First byte after start is 7-bit address plus direction bit (1 = read).
// - Master ends with stop, or issues repeated start to address again.
// - Data line changes only while clock is low.
// - Master clocks a ninth acknowledge bit; transmitter releases, receiver pulls low.
// - Unmatched slave leaves data high; master then issues stop.
// - Master receiver acknowledges all bytes but the last; slave then releases.
// - Master starts a transfer only while the bus is idle.
// - Master losing arbitration releases the bus until it is idle again.
// - Arbitration covers address bits and continues through data bits.
// - Clock low lasts 6 units, high 4; unit is 2*(1+period) clocks.
// - Period setting reaches both 100 and 400 kbit/s rates.
// - Master and slave run independently and at once on the same pins.
// - Master signals completion of each operation and of an error abort.
// - Slave signals received data and data requested by a master.
// - Multimaster with clock synchronisation; 7-bit addressing only.
// - Master flags error on missing acknowledge and on lost arbitration.
module two_wire_master_slave_bus_unit
	import two_wire_pkg::*;
#(
	parameter int TPR_WIDTH  = 8,
	parameter int FIFO_DEPTH = `TW_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Clock line pin
	input  wire logic                 serial_clock_pin_in,
	output logic                      serial_clock_pin_out,
	output logic                      serial_clock_pin_oe_n,
	// Data line pin
	input  wire logic                 serial_data_pin_in,
	output logic                      serial_data_pin_out,
	output logic                      serial_data_pin_oe_n,
	// Master setup
	input  wire logic [TPR_WIDTH-1:0] timer_period_value,
	input  wire logic [7:0]           master_target_address_reg,
	// Master command
	input  wire logic                 m_cmd_valid,
	output logic                      m_cmd_ready,
	input  wire logic                 m_cmd_start,
	input  wire logic                 m_cmd_stop,
	input  wire logic                 m_cmd_ack,
	input  wire logic [7:0]           m_tx_data,
	// Master result
	output logic                      m_done,
	output logic                      m_error,
	output logic                      m_nack,
	output logic                      m_arb_lost,
	output logic [7:0]                m_rx_data,
	output logic                      bus_busy,
	// Slave setup
	input  wire logic                 slave_enable,
	input  wire logic [6:0]           slave_own_address,
	// Slave transmit
	output logic                      s_tx_request,
	input  wire logic                 s_tx_valid,
	output logic                      s_tx_taken,
	input  wire logic [7:0]           s_tx_data,
	// Slave receive stream
	output logic                      s_rx_event,
	output logic                      s_rx_valid,
	input  wire logic                 s_rx_ready,
	output logic [7:0]                s_rx_data,
	output logic                      s_rx_first
);

	// ==========================================================
	// Parameter check
	if (TPR_WIDTH < 5 || TPR_WIDTH > 16) begin : g_bad_param
		$error("two_wire unit: TPR_WIDTH must lie in 5..16 to reach the standard rate");
	end

	// ==========================================================
	// Pin synchronisers and line events
	logic scl_meta_q, scl_s_q, scl_d1_q;
	logic sda_meta_q, sda_s_q, sda_d1_q;
	logic busy_q;

	// Two flops before anything looks at a pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_meta_q <= 1'b1;
			scl_s_q    <= 1'b1;
			scl_d1_q   <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_s_q    <= 1'b1;
			sda_d1_q   <= 1'b1;
		end else begin
			scl_meta_q <= serial_clock_pin_in;
			scl_s_q    <= scl_meta_q;
			scl_d1_q   <= scl_s_q;
			sda_meta_q <= serial_data_pin_in;
			sda_s_q    <= sda_meta_q;
			sda_d1_q   <= sda_s_q;
		end
	end

	// Start/stop detection and edges of the clock line
	wire start_det = scl_s_q && scl_d1_q && sda_d1_q && !sda_s_q;
	wire stop_det  = scl_s_q && scl_d1_q && !sda_d1_q && sda_s_q;
	wire scl_rise  = scl_s_q && !scl_d1_q;
	wire scl_fall  = !scl_s_q && scl_d1_q;
	wire bus_idle  = !busy_q && scl_s_q && sda_s_q;

	// Busy from start until stop, seen from any master
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1;
		end else if (stop_det) begin
			busy_q <= 1'b0;
		end
	end

	// ==========================================================
	// Master timer: one unit is 2*(1+period) system clocks
	master_state_t        m_state_q, m_state_d;
	logic [TPR_WIDTH:0]   pre_q;
	logic [2:0]           unit_q;
	wire                  tick     = pre_q == {timer_period_value, 1'b1};
	wire                  m_lowish = m_state_q inside {M_LOW, M_RS_LOW, M_STOP_LOW};
	wire  [2:0]           target   = m_lowish ? `TW_LOW_PHASE_UNITS : `TW_HIGH_PHASE_UNITS;
	wire                  phase_end = tick && (unit_q == target - 3'h1);
	wire                  first_unit = m_lowish && tick && (unit_q == 3'h0);

	// Restarted on every state change so each phase is timed whole
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q  <= '0;
			unit_q <= 3'h0;
		end else if (m_state_d != m_state_q || tick) begin
			pre_q  <= '0;
			unit_q <= (m_state_d != m_state_q) ? 3'h0 : unit_q + 3'h1;
		end else begin
			pre_q  <= pre_q + 1'b1;
		end
	end

	// ==========================================================
	// Master sequencer
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d, data_q, data_d;
	logic       addr_ph_q, addr_ph_d, rd_q, rd_d, ack_q, ack_d, stop_q, stop_d;
	logic       m_sda_low_q, m_sda_low_d;
	logic       done_d, err_d, nack_d, arb_d, ready_d;
	logic [7:0] rx_d;

	wire accept   = m_cmd_valid && m_cmd_ready &&
	                ((m_state_q == M_HOLD) || (m_state_q == M_IDLE && bus_idle));
	wire data_rd  = rd_q && !addr_ph_q;
	// Bit placed on the line: shifted data, released for read data bits and for address and write ack slots, driven from ack in read data ack slots
	wire out_bit  = (bit_q == `TW_DATA_BITS) ? (data_rd ? !ack_q : 1'b1)
	                                         : (data_rd ? 1'b1 : sh_q[7]);
	wire m_scl_low_d = m_state_d inside {M_HOLD, M_LOW, M_RS_LOW, M_STOP_LOW};

	always_comb begin
		m_state_d   = m_state_q;
		bit_d       = bit_q;
		sh_d        = sh_q;
		data_d      = data_q;
		addr_ph_d   = addr_ph_q;
		rd_d        = rd_q;
		ack_d       = ack_q;
		stop_d      = stop_q;
		m_sda_low_d = m_sda_low_q;
		done_d      = 1'b0;
		err_d       = m_error;
		nack_d      = m_nack;
		arb_d       = m_arb_lost;
		rx_d        = m_rx_data;
		// Data moves one unit into the low phase, never with clock high
		if (first_unit) begin
			m_sda_low_d = (m_state_q == M_LOW) ? !out_bit : (m_state_q == M_STOP_LOW);
		end
		case (m_state_q)
			M_IDLE, M_HOLD: begin
				if (accept) begin
					data_d    = m_tx_data;
					ack_d     = m_cmd_ack;
					stop_d    = m_cmd_stop;
					err_d     = 1'b0;
					nack_d    = 1'b0;
					arb_d     = 1'b0;
					bit_d     = 4'h0;
					if (m_state_q == M_IDLE || m_cmd_start) begin
						sh_d      = master_target_address_reg;
						rd_d      = master_target_address_reg[0];
						addr_ph_d = 1'b1;
						m_state_d = (m_state_q == M_IDLE) ? M_START : M_RS_LOW;
					end else begin
						sh_d      = m_tx_data;
						addr_ph_d = 1'b0;
						m_state_d = M_LOW;
					end
				end
			end
			M_START: begin
				m_sda_low_d = 1'b1;
				if (phase_end) m_state_d = M_LOW;
			end
			M_LOW:       if (phase_end) m_state_d = M_RISE;
			M_RISE:      if (scl_s_q) m_state_d = M_HIGH;
			M_HIGH: begin
				// Another master pulling clock low ends our high phase early
				if (phase_end || !scl_s_q) begin
					if (bit_q != `TW_DATA_BITS) begin
						if (!data_rd && out_bit && !sda_s_q) begin
							m_sda_low_d = 1'b0;
							arb_d       = 1'b1;
							err_d       = 1'b1;
							done_d      = 1'b1;
							m_state_d   = M_IDLE;
						end else begin
							sh_d      = {sh_q[6:0], sda_s_q};
							bit_d     = bit_q + 4'h1;
							m_state_d = M_LOW;
						end
					end else if (!data_rd && sda_s_q) begin
						nack_d    = 1'b1;
						err_d     = 1'b1;
						done_d    = 1'b1;
						m_state_d = M_STOP_LOW;
					end else if (addr_ph_q) begin
						addr_ph_d = 1'b0;
						bit_d     = 4'h0;
						sh_d      = data_q;
						m_state_d = M_LOW;
					end else begin
						if (data_rd) rx_d = sh_q;
						done_d    = 1'b1;
						m_state_d = stop_q ? M_STOP_LOW : M_HOLD;
					end
				end
			end
			M_RS_LOW:    if (phase_end) m_state_d = M_RS_RISE;
			M_RS_RISE:   if (scl_s_q) m_state_d = M_RS_HIGH;
			M_RS_HIGH:   if (phase_end) m_state_d = M_START;
			M_STOP_LOW:  if (phase_end) m_state_d = M_STOP_RISE;
			M_STOP_RISE: if (scl_s_q) m_state_d = M_STOP_HIGH;
			M_STOP_HIGH: begin
				if (phase_end) begin
					m_sda_low_d = 1'b0;
					m_state_d   = M_STOP_FREE;
				end
			end
			M_STOP_FREE: if (phase_end) m_state_d = M_IDLE;
			default:     m_state_d = M_IDLE;
		endcase
		// Ready only in a state that can take a command next cycle
		ready_d = !accept && ((m_state_d == M_HOLD) || (m_state_d == M_IDLE && bus_idle));
	end

	// Master state and result flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			m_state_q   <= M_IDLE;
			bit_q       <= 4'h0;
			sh_q        <= 8'h00;
			data_q      <= 8'h00;
			addr_ph_q   <= 1'b0;
			rd_q        <= 1'b0;
			ack_q       <= 1'b0;
			stop_q      <= 1'b0;
			m_sda_low_q <= 1'b0;
			m_cmd_ready <= 1'b0;
			m_done      <= 1'b0;
			m_error     <= 1'b0;
			m_nack      <= 1'b0;
			m_arb_lost  <= 1'b0;
			m_rx_data   <= 8'h00;
		end else begin
			m_state_q   <= m_state_d;
			bit_q       <= bit_d;
			sh_q        <= sh_d;
			data_q      <= data_d;
			addr_ph_q   <= addr_ph_d;
			rd_q        <= rd_d;
			ack_q       <= ack_d;
			stop_q      <= stop_d;
			m_sda_low_q <= m_sda_low_d;
			m_cmd_ready <= ready_d;
			m_done      <= done_d;
			m_error     <= err_d;
			m_nack      <= nack_d;
			m_arb_lost  <= arb_d;
			m_rx_data   <= rx_d;
		end
	end

	// ==========================================================
	// Slave sequencer, driven by clock line edges
	slave_state_t s_state_q, s_state_d;
	logic [7:0]   s_sh_q, s_sh_d;
	logic [3:0]   s_cnt_q, s_cnt_d;
	logic         s_rd_q, s_rd_d, s_first_q, s_first_d;
	logic         s_sda_low_q, s_sda_low_d, s_scl_low_q;
	logic         req_d, taken_d, fifo_in_ready, push;

	wire addr_hit = slave_enable && (s_sh_q[7:1] == slave_own_address);
	wire rx_full  = (s_state_q == S_RX) && (s_cnt_q == `TW_DATA_BITS) && (scl_fall || s_scl_low_q);
	// Clock stays low while waiting, and one cycle past so data settles first
	wire s_scl_low_d = (rx_full && !fifo_in_ready) || (s_state_q == S_TX_WAIT) ||
	                   (rx_full && fifo_in_ready);
	assign push = rx_full && fifo_in_ready;

	always_comb begin
		s_state_d   = s_state_q;
		s_sh_d      = s_sh_q;
		s_cnt_d     = s_cnt_q;
		s_rd_d      = s_rd_q;
		s_first_d   = s_first_q;
		s_sda_low_d = s_sda_low_q;
		req_d       = 1'b0;
		taken_d     = 1'b0;
		if (stop_det) begin
			s_state_d   = S_IDLE;
			s_sda_low_d = 1'b0;
		end else if (start_det) begin
			s_state_d   = S_ADDR;                                   // repeated start too
			s_cnt_d     = 4'h0;
			s_sda_low_d = 1'b0;
		end else begin
			case (s_state_q)
				S_IDLE: ;
				S_ADDR, S_RX: begin
					if (scl_rise && s_cnt_q != `TW_DATA_BITS) begin
						s_sh_d  = {s_sh_q[6:0], sda_s_q};
						s_cnt_d = s_cnt_q + 4'h1;
					end else if (s_state_q == S_ADDR && scl_fall && s_cnt_q == `TW_DATA_BITS) begin
						if (addr_hit) begin
							s_rd_d      = s_sh_q[0];
							s_first_d   = 1'b1;
							s_sda_low_d = 1'b1;
							s_state_d   = S_ACK;
						end else begin
							s_state_d   = S_IDLE;
						end
					end else if (push) begin
						s_sda_low_d = 1'b1;
						s_state_d   = S_ACK;
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						s_sda_low_d = 1'b0;
						s_cnt_d     = 4'h0;
						s_state_d   = s_rd_q ? S_TX_WAIT : S_RX;
						req_d       = s_rd_q;
					end
				end
				S_TX_WAIT: begin
					if (s_tx_valid) begin
						s_sh_d      = s_tx_data;
						s_sda_low_d = !s_tx_data[7];
						s_cnt_d     = 4'h1;
						taken_d     = 1'b1;
						s_state_d   = S_TX;
					end
				end
				S_TX: begin
					if (scl_fall) begin
						s_sh_d      = {s_sh_q[6:0], 1'b0};
						s_sda_low_d = (s_cnt_q != `TW_DATA_BITS) && !s_sh_q[6];
						s_cnt_d     = s_cnt_q + 4'h1;
						if (s_cnt_q == `TW_DATA_BITS) s_state_d = S_TX_ACK;
					end
				end
				S_TX_ACK: begin
					if (scl_rise) s_state_d = sda_s_q ? S_IDLE : S_ACK;
				end
				default: s_state_d = S_IDLE;
			endcase
		end
		if (push) s_first_d = 1'b0;
	end

	// Slave flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_state_q    <= S_IDLE;
			s_sh_q       <= 8'h00;
			s_cnt_q      <= 4'h0;
			s_rd_q       <= 1'b0;
			s_first_q    <= 1'b0;
			s_sda_low_q  <= 1'b0;
			s_scl_low_q  <= 1'b0;
			s_tx_request <= 1'b0;
			s_tx_taken   <= 1'b0;
			s_rx_event   <= 1'b0;
		end else begin
			s_state_q    <= s_state_d;
			s_sh_q       <= s_sh_d;
			s_cnt_q      <= s_cnt_d;
			s_rd_q       <= s_rd_d;
			s_first_q    <= s_first_d;
			s_sda_low_q  <= s_sda_low_d;
			s_scl_low_q  <= s_scl_low_d;
			s_tx_request <= req_d;
			s_tx_taken   <= taken_d;
			s_rx_event   <= push;
		end
	end

	// ==========================================================
	// Received bytes, tagged with a first-byte flag
	byte_fifo #(
		.WIDTH (`TW_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (rx_full),
		.in_ready  (fifo_in_ready),
		.in_data   ({s_first_q, s_sh_q}),
		.out_valid (s_rx_valid),
		.out_ready (s_rx_ready),
		.out_data  ({s_rx_first, s_rx_data})
	);

	// ==========================================================
	// Shared open-drain pins: either side may pull low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_clock_pin_out  <= 1'b0;
			serial_data_pin_out   <= 1'b0;
			serial_clock_pin_oe_n <= 1'b1;
			serial_data_pin_oe_n  <= 1'b1;
			bus_busy              <= 1'b0;
		end else begin
			serial_clock_pin_out  <= 1'b0;
			serial_data_pin_out   <= 1'b0;
			serial_clock_pin_oe_n <= !(m_scl_low_d || s_scl_low_d);
			serial_data_pin_oe_n  <= !(m_sda_low_d || s_sda_low_d);
			bus_busy              <= start_det || (busy_q && !stop_det);
		end
	end

endmodule : two_wire_master_slave_bus_unit

`default_nettype wire

// file: two_wire_params.svh
// Timing figures and field constants for the two-wire bus unit
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

// ==========================================================
// System clock
`define TW_SYS_CLK_PERIOD_NS 20
`define TW_SYS_CLK_KHZ       (1000000 / `TW_SYS_CLK_PERIOD_NS)

// ==========================================================
// Clock line phase lengths, in timer units
`define TW_LOW_PHASE_UNITS   3'h6
`define TW_HIGH_PHASE_UNITS  3'h4
`define TW_PHASE_SUM         (6 + 4)

// ==========================================================
// Bus rates and the period settings that reach them
`define TW_STD_RATE_KBPS     100
`define TW_FAST_RATE_KBPS    400
// Smallest setting whose rate does not exceed the given one
`define TW_TPR_FOR(kbps) \
	((`TW_SYS_CLK_KHZ + 2 * `TW_PHASE_SUM * (kbps) - 1) / (2 * `TW_PHASE_SUM * (kbps)) - 1)

// ==========================================================
// Byte framing
`define TW_DATA_BITS         4'h8
`define TW_ADDR_BITS         7

// ==========================================================
// Receive buffer defaults
`define TW_FIFO_DEPTH        4
`define TW_FIFO_WIDTH        9

`endif

// file: two_wire_pkg.sv
// Types shared by the two-wire bus unit
package two_wire_pkg;

	// ==========================================================
	// Master sequencer states
	typedef enum logic [3:0] {
		M_IDLE, M_HOLD, M_START, M_LOW, M_RISE, M_HIGH,
		M_RS_LOW, M_RS_RISE, M_RS_HIGH,
		M_STOP_LOW, M_STOP_RISE, M_STOP_HIGH, M_STOP_FREE
	} master_state_t;

	// ==========================================================
	// Slave sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK, S_RX, S_TX_WAIT, S_TX, S_TX_ACK
	} slave_state_t;

endpackage : two_wire_pkg

// file: byte_fifo.sv
// Shift-register FIFO with registered head and valid flags
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	// ==========================================================
	// Parameter check
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
		$error("byte_fifo: DEPTH must be at least 2 and WIDTH at least 1");
	end

	// ==========================================================
	// Storage
	logic [DEPTH:0]   valid_q;
	logic [WIDTH-1:0] data_q [DEPTH+1];
	logic [DEPTH:0]   vshift;
	logic             push;
	logic             pop;

	// Head entry is a flop, so the drain side sees registered outputs
	assign out_valid = valid_q[0];
	assign out_data  = data_q[0];
	assign in_ready  = !valid_q[DEPTH-1];
	assign push      = in_valid && in_ready;
	assign pop       = valid_q[0] && out_ready;
	assign vshift[DEPTH] = 1'b0;

	// Top spare slot never fills; it only feeds the shift
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valid_q[DEPTH] <= 1'b0;
			data_q[DEPTH]  <= '0;
		end else begin
			valid_q[DEPTH] <= 1'b0;
			data_q[DEPTH]  <= '0;
		end
	end

	// Per entry: shift down on pop, load new word at first free slot
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		logic load;
		assign vshift[i] = pop ? valid_q[i+1] : valid_q[i];
		if (i == 0) begin : g_first
			assign load = push && !vshift[0];
		end else begin : g_rest
			assign load = push && !vshift[i] && vshift[i-1];
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				valid_q[i] <= 1'b0;
				data_q[i]  <= '0;
			end else begin
				valid_q[i] <= vshift[i] || load;
				data_q[i]  <= load ? in_data : (pop ? data_q[i+1] : data_q[i]);
			end
		end
	end

endmodule : byte_fifo

`default_nettype wire

// file: tw_props.sv
// Concurrent checks on the ports of the two-wire bus unit
`timescale 1ns/100ps
`default_nettype none
module tw_props #(
	parameter int TPR_WIDTH = 8
) (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// Pins
	input wire logic                 serial_clock_pin_in,
	input wire logic                 serial_clock_pin_oe_n,
	input wire logic [TPR_WIDTH-1:0] timer_period_value,
	// Master
	input wire logic                 m_cmd_valid,
	input wire logic                 m_cmd_ready,
	input wire logic                 m_done,
	input wire logic                 m_error,
	input wire logic                 m_nack,
	input wire logic                 m_arb_lost,
	input wire logic                 bus_busy,
	// Slave
	input wire logic                 s_rx_event,
	input wire logic                 s_rx_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int   lo_q;
	int   hi_q;
	logic own_q;
	int   unit;
	// ==========
	// Clock run lengths; own_q marks lows begun on a high wire, so slave stretches are skipped
	assign unit = 2 * (int'(timer_period_value) + 1);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lo_q <= 0;
			hi_q <= 0;
			own_q <= 1'b0;
		end else begin
			lo_q <= serial_clock_pin_oe_n ? 0 : lo_q + 1;
			hi_q <= (serial_clock_pin_oe_n && serial_clock_pin_in) ? hi_q + 1 : 0;
			if (!serial_clock_pin_oe_n && lo_q == 0)
				own_q <= (hi_q != 0);
		end
	end
	// ==========
	// Assertions
	chk_low_phase: assert property ($rose(serial_clock_pin_oe_n) && own_q |-> lo_q >= 6 * unit)
		else $error("clock low phase too short");
	chk_high_phase: assert property ($fell(serial_clock_pin_oe_n) && hi_q != 0 |-> hi_q >= 4 * unit)
		else $error("clock high phase too short");
	chk_done_pulse: assert property (m_done |=> !m_done)
		else $error("done longer than one cycle");
	chk_error_cause: assert property (m_error |-> m_nack || m_arb_lost)
		else $error("error without cause");
	chk_nack_error: assert property ($rose(m_nack) |-> m_error)
		else $error("nack without error");
	chk_nack_stop: assert property ($rose(m_nack) |-> ##[0:400] !bus_busy)
		else $error("no stop after nack");
	chk_done_busy: assert property (m_done && !m_error |-> bus_busy)
		else $error("bus free at byte end");
	chk_take_once: assert property (m_cmd_valid && m_cmd_ready |=> !m_cmd_ready)
		else $error("ready held after take");
	chk_rx_queued: assert property (s_rx_event |-> ##[0:2] s_rx_valid)
		else $error("received byte not queued");
	cov_byte_ok: cover property (m_done && !m_error);
	cov_nack: cover property ($rose(m_nack));
	cov_rx: cover property (s_rx_event);
endmodule : tw_props
bind two_wire_master_slave_bus_unit tw_props #(.TPR_WIDTH(TPR_WIDTH)) u_props (.*);
`default_nettype wire

// file: tw_slave_model.sv
// Far-side slave device that acks its write address and keeps the last byte
`timescale 1ns/100ps
`default_nettype none
module tw_slave_model #(
	parameter logic [6:0] ADDR = 7'h3B
) (
	// Bus lines and pulls
	input wire logic  scl,
	input wire logic  sda,
	output logic      scl_low,
	output logic      sda_low,
	// Control and capture
	input wire logic  stretch,
	output logic [7:0] last_byte
);
	// One pass per byte; a foreign address parks the model until the next start
	task automatic run();
		logic [7:0] sh;
		logic       sel;
		sel = 1'b0;
		for (int n = 0; ; n++) begin
			repeat (8) begin
				@(posedge scl);
				sh = {sh[6:0], sda};
			end
			@(negedge scl);
			if (n == 0)
				sel = (sh[7:1] == ADDR) && !sh[0];
			else
				last_byte = sh;
			if (!sel)
				wait (1'b0);
			sda_low = 1'b1;
			@(negedge scl);
			sda_low = 1'b0;
			if (stretch) begin
				scl_low = 1'b1;
				#1000 scl_low = 1'b0;
			end
		end
	endtask : run
	// Restart on every start, repeated or after a stop
	initial begin
		{scl_low, sda_low, last_byte} = 10'h000;
		@(negedge sda iff scl === 1'b1);
		forever begin
			fork
				run();
				@(negedge sda iff scl === 1'b1);
			join_any
			disable fork;
			sda_low = 1'b0;
		end
	end
endmodule : tw_slave_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the two-wire bus unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic       clk = 1'b0, rst = 1'b1, t_scl = 1'b0, t_sda = 1'b0, stretch = 1'b0;
	logic       valid = 1'b0, start = 1'b0, stop = 1'b0, rx_ready = 1'b0, ack = 1'b1;
	logic [7:0] tpr = 8'h01, target = 8'h00, tx = 8'h00, last, rxd, mrx;
	logic       c_oe_n, d_oe_n, p_scl, p_sda, done, err, nack, arb, busy, ready, rxv, rxf;
	int         fail_count = 0, tests_run = 0, seed = 69442;
	// ==========
	// Clock and pulled-up open-drain lines
	always #10 clk = ~clk;
	wire logic scl = c_oe_n & !p_scl & !t_scl;
	wire logic sda = d_oe_n & !p_sda & !t_sda;
	two_wire_master_slave_bus_unit u_dut (.clk(clk), .rst(rst), .serial_clock_pin_in(scl),
		.serial_clock_pin_out(), .serial_clock_pin_oe_n(c_oe_n), .serial_data_pin_in(sda),
		.serial_data_pin_out(), .serial_data_pin_oe_n(d_oe_n), .timer_period_value(tpr),
		.master_target_address_reg(target), .m_cmd_valid(valid), .m_cmd_ready(ready), .m_cmd_start(start),
		.m_cmd_stop(stop), .m_cmd_ack(ack), .m_tx_data(tx), .m_done(done), .m_error(err), .m_nack(nack),
		.m_arb_lost(arb), .m_rx_data(mrx), .bus_busy(busy), .slave_enable(1'b1), .slave_own_address(7'h55),
		.s_tx_request(), .s_tx_valid(1'b1), .s_tx_taken(), .s_tx_data(tx), .s_rx_event(),
		.s_rx_valid(rxv), .s_rx_ready(rx_ready), .s_rx_data(rxd), .s_rx_first(rxf));
	tw_slave_model u_far (.scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda), .stretch(stretch),
		.last_byte(last));
	// ==========
	// Compare, verdict, stepping
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic tick();
		@(posedge clk);
		#2;
	endtask : tick
	// One master byte: hold the request until taken, then wait for done
	task automatic cmd(input logic s, input logic p, input logic [7:0] d);
		int   n;
		logic r;
		{valid, start, stop, tx} = {1'b1, s, p, d};
		for (n = 0; n < 9000; n++) begin
			r = ready;
			tick();
			if (r === 1'b1)
				break;
		end
		valid = 1'b0;
		for (n = 0; n < 9000 && done !== 1'b1; n++)
			tick();
		if (n == 9000) begin
			chk(9'h000, 9'h001);
			close_out();
		end
	endtask : cmd
	// Far master on a 160 ns link clock, waiting out clock stretches
	task automatic xframe(input logic [7:0] b[$]);
		t_sda = 1'b1;
		#80 t_scl = 1'b1;
		#40;
		foreach (b[k]) begin
			for (int i = 8; i >= 0; i--) begin
				t_sda = (i > 0) && !b[k][(i + 7) % 8];
				#40 t_scl = 1'b0;
				for (int n = 0; n < 99 && !scl; n++) #20;
				chk(scl, 1'b1);
				#40 if (i == 0) chk(sda, 1'b0);
				#40 t_scl = 1'b1;
				#40;
			end
		end
		t_sda = 1'b1;
		#40 t_scl = 1'b0;
		#80 t_sda = 1'b0;
		#160;
	endtask : xframe
	// ==========
	// Scenarios
	initial begin
		logic [7:0] d;
		logic [7:0] q[$];
		logic [8:0] exp[$];
		repeat (4) @(posedge clk);
		#2 rst = 1'b0;
		repeat (3) tick();
		// Unknown address: flagged and stopped
		target = 8'h54;
		cmd(1'b1, 1'b1, 8'hA5);
		chk({err, nack, arb}, 3'b110);
		for (int n = 0; n < 900 && busy !== 1'b0; n++) tick();
		chk(busy, 1'b0);
		// Writes, one stretched, the last after a repeated start
		{tpr, target} = {8'h00, 8'h76};
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			stretch = (k == 1);
			cmd(k == 0 || k == 3, k == 3, d);
			chk(last, d);
			chk({err, busy}, 2'b01);
		end
		for (int n = 0; n < 900 && busy !== 1'b0; n++) tick();
		chk(busy, 1'b0);
		// Own master reads one byte from own slave and leaves it unacknowledged
		{ack, target, d} = {1'b0, 8'hAB, 8'($random(seed))};
		cmd(1'b1, 1'b1, d);
		chk({mrx, err}, {d, 1'b0});
		ack = 1'b1;
		for (int n = 0; n < 900 && busy !== 1'b0; n++) tick();
		chk(busy, 1'b0);
		// Far master writes three bytes into the receive buffer, drained afterwards
		q = {8'hAA};
		for (int k = 0; k < 3; k++) begin
			d = $random(seed);
			q.push_back(d);
			exp.push_back({k == 0, d});
		end
		#3 xframe(q);
		tick();
		rx_ready = 1'b1;
		for (int n = 0; n < 50 && exp.size() > 0; n++) begin
			if (rxv === 1'b1) chk({rxf, rxd}, exp.pop_front());
			tick();
		end
		chk(exp.size(), 0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
